/* File: rtl/atas_regs.sv */
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module atas_regs (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic soft_rst,
   input wire logic ctl_cap_valid,
   input wire logic [atas_pkg::ACK_W-1:0] ctl_ack_code,
   input wire logic bulk_cap_valid,
   input wire logic [atas_pkg::ACK_W-1:0] bulk_ack_code,
   input wire logic [atas_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [atas_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [atas_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [atas_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic link_diagnostics_register_register_write_enable,
   output logic irq
);
   import atas_pkg::*;

   atas_state_e state_reg;
   logic [DATA_W-1:0] wmask;
   logic [NUM_ACK-1:0] cap_valid;
   logic [ACK_W-1:0] cap_code [NUM_ACK];
   logic [ACK_W-1:0] code_reg [NUM_ACK];
   logic [NUM_ACK-1:0] flag_reg;
   logic [NUM_ACK-1:0] wr_hit;
   logic [NUM_ACK-1:0] rd_hit;
   logic [NUM_ACK-1:0] rd_clr;
   logic wr_take;
   logic rd_take;
   logic wr_mapped;
   logic rd_mapped;
   logic [DATA_W-1:0] rd_word;
   logic [NUM_ACK-1:0] irq_status_reg;
   logic [NUM_ACK-1:0] irq_mask_reg;
   logic [NUM_ACK-1:0] irq_status_next;

   assign cap_valid = {bulk_cap_valid, ctl_cap_valid};
   assign cap_code[0] = ctl_ack_code;
   assign cap_code[1] = bulk_ack_code;

   // --------------------------------------------------------------
   // bus handshake
   // --------------------------------------------------------------
   // address and data are taken together; one access at a time keeps
   // a read clear from racing a diagnostic write of the same register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= ATAS_IDLE;
      end else begin
         unique case (state_reg)
            ATAS_IDLE: begin
               if (s_axi_awvalid && s_axi_wvalid) begin
                  state_reg <= ATAS_WACC;
               end else if (s_axi_arvalid) begin
                  state_reg <= ATAS_RACC;
               end
            end
            ATAS_WACC: begin
               state_reg <= ATAS_WRESP;
            end
            ATAS_WRESP: begin
               if (s_axi_bready) begin
                  state_reg <= ATAS_IDLE;
               end
            end
            ATAS_RACC: begin
               state_reg <= ATAS_RRESP;
            end
            ATAS_RRESP: begin
               if (s_axi_rready) begin
                  state_reg <= ATAS_IDLE;
               end
            end
            default: begin
               state_reg <= ATAS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_awready <= (state_reg == ATAS_IDLE) && s_axi_awvalid && s_axi_wvalid;
         s_axi_wready <= (state_reg == ATAS_IDLE) && s_axi_awvalid && s_axi_wvalid;
         s_axi_arready <= (state_reg == ATAS_IDLE) && s_axi_arvalid
                          && !(s_axi_awvalid && s_axi_wvalid);
      end
   end

   assign wr_take = (state_reg == ATAS_WACC);
   assign rd_take = (state_reg == ATAS_RACC);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_take) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= '0;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         s_axi_rdata <= rd_word;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // --------------------------------------------------------------
   // address decode
   // --------------------------------------------------------------
   assign wr_hit[0] = wr_take && (s_axi_awaddr == OFS_CONTROL_ACK);
   assign wr_hit[1] = wr_take && (s_axi_awaddr == OFS_BULK_ACK);
   assign rd_hit[0] = rd_take && (s_axi_araddr == OFS_CONTROL_ACK);
   assign rd_hit[1] = rd_take && (s_axi_araddr == OFS_BULK_ACK);
   assign rd_clr = rd_hit;

   assign wr_mapped = (s_axi_awaddr == OFS_CONTROL_ACK) || (s_axi_awaddr == OFS_BULK_ACK)
                      || (s_axi_awaddr == OFS_LINK_DIAGNOSTICS_REGISTER) || (s_axi_awaddr == OFS_IRQ_STATUS)
                      || (s_axi_awaddr == OFS_IRQ_MASK);
   assign rd_mapped = (s_axi_araddr == OFS_CONTROL_ACK) || (s_axi_araddr == OFS_BULK_ACK)
                      || (s_axi_araddr == OFS_LINK_DIAGNOSTICS_REGISTER) || (s_axi_araddr == OFS_IRQ_STATUS)
                      || (s_axi_araddr == OFS_IRQ_MASK);

   // --------------------------------------------------------------
   // acknowledge registers
   // --------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_strb
         assign wmask[8*gi +: 8] = {8{s_axi_wstrb[gi]}};
      end
      for (gi = 0; gi < NUM_ACK; gi++) begin : g_ack
         logic wr_ok;
         // only the field and flag bits can ever be written
         assign wr_ok = wr_hit[gi] && link_diagnostics_register_register_write_enable;
         // codes pass through untouched: normal ack or error encoding
         atas_ack_slot u_slot (
            .clk(clk),
            .sys_rst(sys_rst),
            .soft_rst(soft_rst),
            .cap_valid(cap_valid[gi]),
            .cap_code(cap_code[gi]),
            .wr_code_mask(wmask[ACK_MSB:ACK_LSB] & {ACK_W{wr_ok}}),
            .wr_code(s_axi_wdata[ACK_MSB:ACK_LSB]),
            .wr_flag_en(wr_ok && wmask[FLAG_BIT]),
            .wr_flag(s_axi_wdata[FLAG_BIT]),
            .rd_clr(rd_clr[gi]),
            .code_reg(code_reg[gi]),
            .flag_reg(flag_reg[gi])
         );
      end
   endgenerate

   // --------------------------------------------------------------
   // diagnostic and interrupt registers
   // --------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         link_diagnostics_register_register_write_enable <= LINK_DIAGNOSTICS_REGISTER_RST;
      end else if (wr_take && (s_axi_awaddr == OFS_LINK_DIAGNOSTICS_REGISTER) && s_axi_wstrb[LINK_DIAGNOSTICS_REGISTER_WE_BIT/8]) begin
         link_diagnostics_register_register_write_enable <= s_axi_wdata[LINK_DIAGNOSTICS_REGISTER_WE_BIT];
      end
   end

   // a capture in the same cycle as a write-one clear keeps the bit set
   always_comb begin
      irq_status_next = irq_status_reg;
      if (wr_take && (s_axi_awaddr == OFS_IRQ_STATUS) && s_axi_wstrb[0]) begin
         irq_status_next = irq_status_reg & ~s_axi_wdata[NUM_ACK-1:0];
      end
      irq_status_next = irq_status_next | cap_valid;
   end

   always_ff @(posedge clk) begin
      if (sys_rst || soft_rst) begin
         irq_status_reg <= IRQ_RST;
      end else begin
         irq_status_reg <= irq_status_next;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_mask_reg <= IRQ_RST;
      end else if (wr_take && (s_axi_awaddr == OFS_IRQ_MASK) && s_axi_wstrb[0]) begin
         irq_mask_reg <= s_axi_wdata[NUM_ACK-1:0];
      end
   end

   // one cycle behind the status bits so the pin comes from a flop
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status_reg & irq_mask_reg);
      end
   end

   // --------------------------------------------------------------
   // read data
   // --------------------------------------------------------------
   always_comb begin
      rd_word = '0;
      unique case (s_axi_araddr)
         OFS_CONTROL_ACK: begin
            rd_word[ACK_MSB:ACK_LSB] = code_reg[0];
            rd_word[FLAG_BIT] = flag_reg[0];
         end
         OFS_BULK_ACK: begin
            rd_word[ACK_MSB:ACK_LSB] = code_reg[1];
            rd_word[FLAG_BIT] = flag_reg[1];
         end
         OFS_LINK_DIAGNOSTICS_REGISTER: begin
            rd_word[LINK_DIAGNOSTICS_REGISTER_WE_BIT] = link_diagnostics_register_register_write_enable;
         end
         OFS_IRQ_STATUS: begin
            rd_word[NUM_ACK-1:0] = irq_status_reg;
         end
         OFS_IRQ_MASK: begin
            rd_word[NUM_ACK-1:0] = irq_mask_reg;
         end
         default: begin
            rd_word = '0;
         end
      endcase
   end

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   sequence s_ctl_rd;
      rd_hit[0] && !ctl_cap_valid && !soft_rst;
   endsequence

   sequence s_bulk_rd;
      rd_hit[1] && !bulk_cap_valid && !soft_rst;
   endsequence

   sequence s_ctl_wr_quiet;
      wr_hit[0] && !ctl_cap_valid && !soft_rst;
   endsequence

   sequence s_bulk_wr_quiet;
      wr_hit[1] && !bulk_cap_valid && !soft_rst;
   endsequence

   chk_ctl_capture: assert property (@(posedge clk) disable iff (sys_rst)
      ctl_cap_valid && !soft_rst |=> code_reg[0] == $past(ctl_ack_code) && flag_reg[0])
      else $error("control ack not captured");

   chk_bulk_capture: assert property (@(posedge clk) disable iff (sys_rst)
      bulk_cap_valid && !soft_rst |=> code_reg[1] == $past(bulk_ack_code) && flag_reg[1])
      else $error("bulk ack not captured");

   chk_sys_reset: assert property (@(posedge clk)
      sys_rst |=> code_reg[0] == ACK_RST && code_reg[1] == ACK_RST && flag_reg == '0)
      else $error("ack registers not cleared by reset");

   chk_soft_reset: assert property (@(posedge clk) disable iff (sys_rst)
      soft_rst |=> code_reg[0] == ACK_RST && code_reg[1] == ACK_RST && flag_reg == '0)
      else $error("ack registers not cleared by software reset");

   chk_ctl_readback: assert property (@(posedge clk) disable iff (sys_rst)
      s_ctl_rd |=> s_axi_rvalid && s_axi_rdata[ACK_MSB:ACK_LSB] == $past(code_reg[0])
                   && s_axi_rdata[FLAG_BIT] == $past(flag_reg[0]))
      else $error("control ack read data wrong");

   chk_err_code: assert property (@(posedge clk) disable iff (sys_rst)
      bulk_cap_valid && bulk_ack_code[ACK_W-1] && !soft_rst ##1 !bulk_cap_valid
      |-> code_reg[1][ACK_W-1] && code_reg[1][3:0] == $past(bulk_ack_code[3:0]))
      else $error("error ack encoding lost");

   chk_ctl_ro: assert property (@(posedge clk) disable iff (sys_rst)
      s_ctl_wr_quiet and !link_diagnostics_register_register_write_enable
      |=> $stable(code_reg[0]) && $stable(flag_reg[0]))
      else $error("control ack changed without diagnostic mode");

   chk_ctl_link_diagnostics_register_wr: assert property (@(posedge clk) disable iff (sys_rst)
      s_ctl_wr_quiet and link_diagnostics_register_register_write_enable && (&s_axi_wstrb[3:2])
      |=> code_reg[0] == $past(s_axi_wdata[ACK_MSB:ACK_LSB])
          && flag_reg[0] == $past(s_axi_wdata[FLAG_BIT]))
      else $error("diagnostic write to control ack lost");

   chk_bulk_ro: assert property (@(posedge clk) disable iff (sys_rst)
      s_bulk_wr_quiet and !link_diagnostics_register_register_write_enable
      |=> $stable(code_reg[1]) && $stable(flag_reg[1]))
      else $error("bulk ack changed without diagnostic mode");

   chk_bulk_link_diagnostics_register_wr: assert property (@(posedge clk) disable iff (sys_rst)
      s_bulk_wr_quiet and link_diagnostics_register_register_write_enable && (&s_axi_wstrb[3:2])
      |=> code_reg[1] == $past(s_axi_wdata[ACK_MSB:ACK_LSB])
          && flag_reg[1] == $past(s_axi_wdata[FLAG_BIT]))
      else $error("diagnostic write to bulk ack lost");

   chk_ctl_rd_clear: assert property (@(posedge clk) disable iff (sys_rst)
      s_ctl_rd |=> !flag_reg[0] && s_axi_rdata[FLAG_BIT] == $past(flag_reg[0]))
      else $error("control flag not cleared by read");

   chk_bulk_rd_clear: assert property (@(posedge clk) disable iff (sys_rst)
      s_bulk_rd |=> !flag_reg[1] && s_axi_rdata[FLAG_BIT] == $past(flag_reg[1]))
      else $error("bulk flag not cleared by read");

   chk_unused_zero: assert property (@(posedge clk) disable iff (sys_rst)
      (rd_hit[0] || rd_hit[1]) |=> s_axi_rdata[ACK_LSB-1:0] == '0
                                  && s_axi_rdata[FLAG_BIT-1:ACK_MSB+1] == '0)
      else $error("unused ack bits read nonzero");

   // capture sets status one cycle on, the pin follows one cycle after that
   chk_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
      ctl_cap_valid && !soft_rst ##1 irq_mask_reg[IRQ_CTL_BIT] |=> irq)
      else $error("interrupt level does not follow status and mask");

endmodule : atas_regs

`default_nettype wire

/* File: rtl/atas_pkg.sv */

package atas_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int ACK_W = 5;
   localparam int NUM_ACK = 2;

   // --------------------------------------------------------------
   // register offsets
   // --------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CONTROL_ACK = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_BULK_ACK = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_LINK_DIAGNOSTICS_REGISTER = 12'h030;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h100;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h104;

   // --------------------------------------------------------------
   // field positions
   // --------------------------------------------------------------
   localparam int ACK_LSB = 23;
   localparam int ACK_MSB = 27;
   localparam int FLAG_BIT = 31;
   localparam int LINK_DIAGNOSTICS_REGISTER_WE_BIT = 4;
   localparam int IRQ_CTL_BIT = 0;
   localparam int IRQ_BULK_BIT = 1;

   // --------------------------------------------------------------
   // reset values and codes
   // --------------------------------------------------------------
   localparam logic [ACK_W-1:0] ACK_RST = 5'h00;
   localparam logic FLAG_RST = 1'b0;
   localparam logic LINK_DIAGNOSTICS_REGISTER_RST = 1'b0;
   localparam logic [NUM_ACK-1:0] IRQ_RST = 2'h0;
   localparam logic [3:0] ACK_ERR_TIMEOUT = 4'h0;
   localparam logic [3:0] ACK_ERR_LONG = 4'h1;
   localparam logic [3:0] ACK_ERR_SHORT = 4'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ATAS_IDLE = 3'b000,
      ATAS_WACC = 3'b001,
      ATAS_WRESP = 3'b010,
      ATAS_RACC = 3'b011,
      ATAS_RRESP = 3'b100
   } atas_state_e;

endpackage : atas_pkg

/* File: rtl/atas_ack_slot.sv */
`timescale 1ns/1ps
`default_nettype none

module atas_ack_slot (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic soft_rst,
   input wire logic cap_valid,
   input wire logic [atas_pkg::ACK_W-1:0] cap_code,
   input wire logic [atas_pkg::ACK_W-1:0] wr_code_mask,
   input wire logic [atas_pkg::ACK_W-1:0] wr_code,
   input wire logic wr_flag_en,
   input wire logic wr_flag,
   input wire logic rd_clr,
   output logic [atas_pkg::ACK_W-1:0] code_reg,
   output logic flag_reg
);
   import atas_pkg::*;

   // --------------------------------------------------------------
   // acknowledge field
   // --------------------------------------------------------------
   // the transmitter's capture beats a diagnostic write in the same cycle
   always_ff @(posedge clk) begin
      if (sys_rst || soft_rst) begin
         code_reg <= ACK_RST;
      end else if (cap_valid) begin
         code_reg <= cap_code;
      end else begin
         code_reg <= (code_reg & ~wr_code_mask) | (wr_code & wr_code_mask);
      end
   end

   // --------------------------------------------------------------
   // new-value flag
   // --------------------------------------------------------------
   // a fresh ack wins over a read clear, so no capture goes unseen
   always_ff @(posedge clk) begin
      if (sys_rst || soft_rst) begin
         flag_reg <= FLAG_RST;
      end else if (cap_valid) begin
         flag_reg <= 1'b1;
      end else if (wr_flag_en) begin
         flag_reg <= wr_flag;
      end else if (rd_clr) begin
         flag_reg <= 1'b0;
      end
   end

endmodule : atas_ack_slot

`default_nettype wire

/* File: tb/atas_testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import atas_pkg::*;

   logic clk, sys_rst, soft_rst, ctl_cap_valid, bulk_cap_valid;
   logic [ACK_W-1:0] ctl_ack_code, bulk_ack_code;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic link_diagnostics_register_register_write_enable, irq;
   int fails = 0;
   int total_checks = 0;

   atas_regs DUT (.clk, .sys_rst, .soft_rst, .ctl_cap_valid, .ctl_ack_code, .bulk_cap_valid,
      .bulk_ack_code, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .link_diagnostics_register_register_write_enable, .irq);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   function automatic logic [31:0] ack_word(input logic flag, input logic [4:0] code);
      return {flag, 3'h0, code, 23'h0};
   endfunction : ack_word

   // master waits on handshakes only; cycle count is just a hang guard
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic aw_ok, w_ok;
      n = 0;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok) && n < 50) begin
         @(posedge clk);
         n++;
         if (s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      chk(32'(s_axi_bresp), 32'(er), "write response");
      s_axi_bready <= 1'b0;
      if (n >= 50) fails++;
      @(posedge clk);
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (n < 50) begin
         @(posedge clk);
         n++;
         if (s_axi_arready === 1'b1) break;
      end
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      chk(s_axi_rdata, exp, "read data");
      chk(32'(s_axi_rresp), 32'(er), "read response");
      s_axi_rready <= 1'b0;
      if (n >= 50) fails++;
      @(posedge clk);
   endtask : axi_rd

   task automatic capture(input logic bulk, input logic [4:0] code);
      if (bulk) begin
         bulk_cap_valid <= 1'b1;
         bulk_ack_code <= code;
      end else begin
         ctl_cap_valid <= 1'b1;
         ctl_ack_code <= code;
      end
      @(posedge clk);
      if (bulk) begin
         bulk_cap_valid <= 1'b0;
      end else begin
         ctl_cap_valid <= 1'b0;
      end
   endtask : capture

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_vals;
      axi_rd(OFS_CONTROL_ACK, 32'h0, RESP_OKAY);
      axi_rd(OFS_BULK_ACK, 32'h0, RESP_OKAY);
      axi_rd(12'h200, 32'h0, RESP_SLVERR);
      $display("test reset values done");
   endtask : t_reset_vals

   task automatic t_capture;
      logic [4:0] codes [5] = '{5'h10, 5'h11, 5'h12, 5'h0d, 5'h02};
      foreach (codes[i]) begin
         capture(1'b0, codes[i]);
         axi_rd(OFS_CONTROL_ACK, ack_word(1'b1, codes[i]), RESP_OKAY);
         axi_rd(OFS_CONTROL_ACK, ack_word(1'b0, codes[i]), RESP_OKAY);
         capture(1'b1, codes[i]);
         axi_rd(OFS_BULK_ACK, ack_word(1'b1, codes[i]), RESP_OKAY);
         axi_rd(OFS_BULK_ACK, ack_word(1'b0, codes[i]), RESP_OKAY);
      end
      // back to back: strobe held for two edges, the later ack must win
      ctl_cap_valid <= 1'b1;
      ctl_ack_code <= 5'h11;
      @(posedge clk);
      ctl_ack_code <= 5'h03;
      @(posedge clk);
      ctl_cap_valid <= 1'b0;
      axi_rd(OFS_CONTROL_ACK, ack_word(1'b1, 5'h03), RESP_OKAY);
      $display("test capture done");
   endtask : t_capture

   task automatic t_link_diagnostics_register_write;
      axi_wr(OFS_CONTROL_ACK, 32'hffff_ffff, RESP_OKAY);
      axi_rd(OFS_CONTROL_ACK, ack_word(1'b0, 5'h03), RESP_OKAY);
      axi_wr(OFS_BULK_ACK, 32'hffff_ffff, RESP_OKAY);
      axi_rd(OFS_BULK_ACK, ack_word(1'b0, 5'h02), RESP_OKAY);
      axi_wr(OFS_LINK_DIAGNOSTICS_REGISTER, 32'h0000_0010, RESP_OKAY);
      chk(32'(link_diagnostics_register_register_write_enable), 32'h1, "link_diagnostics_register enable");
      axi_wr(OFS_CONTROL_ACK, 32'h7fff_ffff, RESP_OKAY);
      axi_rd(OFS_CONTROL_ACK, 32'h0f80_0000, RESP_OKAY);
      axi_wr(OFS_CONTROL_ACK, 32'h8000_0000, RESP_OKAY);
      axi_rd(OFS_CONTROL_ACK, 32'h8000_0000, RESP_OKAY);
      axi_wr(OFS_BULK_ACK, 32'hffff_ffff, RESP_OKAY);
      axi_rd(OFS_BULK_ACK, 32'h8f80_0000, RESP_OKAY);
      axi_wr(OFS_LINK_DIAGNOSTICS_REGISTER, 32'h0, RESP_OKAY);
      axi_wr(OFS_BULK_ACK, 32'h8000_0000, RESP_OKAY);
      axi_rd(OFS_BULK_ACK, 32'h0f80_0000, RESP_OKAY);
      $display("test diagnostic write done");
   endtask : t_link_diagnostics_register_write

   task automatic t_irq;
      axi_wr(OFS_IRQ_STATUS, 32'h3, RESP_OKAY);
      axi_wr(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
      capture(1'b1, 5'h01);
      repeat (3) @(posedge clk);
      chk(32'(irq), 32'h0, "masked irq");
      axi_rd(OFS_IRQ_STATUS, 32'h2, RESP_OKAY);
      capture(1'b0, 5'h01);
      repeat (3) @(posedge clk);
      chk(32'(irq), 32'h1, "irq raised");
      axi_wr(OFS_IRQ_STATUS, 32'h1, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0, "irq cleared");
      $display("test interrupt done");
   endtask : t_irq

   task automatic t_soft_reset;
      capture(1'b0, 5'h12);
      capture(1'b1, 5'h10);
      soft_rst <= 1'b1;
      @(posedge clk);
      soft_rst <= 1'b0;
      axi_rd(OFS_CONTROL_ACK, 32'h0, RESP_OKAY);
      axi_rd(OFS_BULK_ACK, 32'h0, RESP_OKAY);
      // status is cleared by the soft reset, the mask is not
      axi_rd(OFS_IRQ_STATUS, 32'h0, RESP_OKAY);
      axi_rd(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
      chk(32'(irq), 32'h0, "irq after soft reset");
      $display("test soft reset done");
   endtask : t_soft_reset

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      sys_rst = 1'b1;
      soft_rst = 1'b0;
      ctl_cap_valid = 1'b0;
      bulk_cap_valid = 1'b0;
      ctl_ack_code = 5'h00;
      bulk_ack_code = 5'h00;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset_vals();
      t_capture();
      t_link_diagnostics_register_write();
      t_irq();
      t_soft_reset();
      wrap_up();
   end

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      wrap_up();
   end

endmodule : testbench

`default_nettype wire
